// [pkg/aicr_defines.vh]
// Constants for the analog input configuration and report block
`ifndef AICR_DEFINES_VH
`define AICR_DEFINES_VH

// ----------------------------------------------------------------
// Register map (word addresses on the plain register port)
// ----------------------------------------------------------------
`define AICR_ADDR_W          5
`define AICR_DATA_W          16
`define AICR_CHAN_BASE       5'h00
`define AICR_STATUS_ADDR     5'h10
`define AICR_MASK_ADDR       5'h11
`define AICR_CONFIG_ADDR     5'h12

// ----------------------------------------------------------------
// Status and mask bits
// ----------------------------------------------------------------
`define AICR_ST_INIT_DONE    0
`define AICR_ST_OOR          1
`define AICR_ST_W            2
`define AICR_MASK_RESET      2'h0

// ----------------------------------------------------------------
// Report values
// ----------------------------------------------------------------
`define AICR_INIT_VALUE      16'h4000
`define AICR_OVER_VALUE      16'h2710
`define AICR_MAX_CHANNELS    16
`define AICR_DIFF_CHANNELS   8

// ----------------------------------------------------------------
// Ranges in millivolts, scale factors in counts per mV, Q16
// ----------------------------------------------------------------
`define AICR_RANGE10_MV      17'h02710
`define AICR_RANGE5_MV       17'h01388
`define AICR_F4096_R10       18'h068dc
`define AICR_F4096_R5        18'h0d1b7
`define AICR_FFULL_R10       18'h0c000
`define AICR_FFULL_R5        18'h18000
`define AICR_F10000_R10      18'h10000
`define AICR_F10000_R5       18'h20000
`define AICR_F4095_R10       18'h068d5
`define AICR_F4095_R5        18'h0d1aa

// ----------------------------------------------------------------
// Filter shifts (2N for N = 8, 16, 32) and fraction bits
// ----------------------------------------------------------------
`define AICR_FRAC_W          6
`define AICR_SHIFT_N8        3'h4
`define AICR_SHIFT_N16       3'h5
`define AICR_SHIFT_N32       3'h6

// ----------------------------------------------------------------
// Indicator timing
// ----------------------------------------------------------------
`define AICR_CLK_MHZ         250
`define AICR_FAST_HALF_MS    50
`define AICR_SLOW_HALF_MS    500
`define AICR_FAST_HALF_CYC   (`AICR_FAST_HALF_MS * 1000 * `AICR_CLK_MHZ)
`define AICR_SLOW_HALF_CYC   (`AICR_SLOW_HALF_MS * 1000 * `AICR_CLK_MHZ)

`endif

// [hw/aicr_top.v]
// Analog input configuration decode, scaling, averaging and host report
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "aicr_defines.vh"
module aicr_top #(
  parameter FAST_HALF_CYC = `AICR_FAST_HALF_CYC,
  parameter SLOW_HALF_CYC = `AICR_SLOW_HALF_CYC
) (
  // Clock, reset, enable
  input  wire                     clk,
  input  wire                     nrst,
  input  wire                     clk_en,
  // Configuration switches (1 = right position)
  input  wire                     polarity_select_switch,
  input  wire                     offset_select_switch,
  input  wire                     format_select_switch_a,
  input  wire                     format_select_switch_b,
  input  wire                     averaging_select_switch_a,
  input  wire                     averaging_select_switch_b,
  input  wire                     channel_mode_switch,
  input  wire                     range_select_switch,
  // Converter samples
  input  wire                     sample_valid,
  input  wire [3:0]               sample_channel,
  input  wire signed [15:0]       sample_mv,
  // Host link state
  input  wire                     host_link_up,
  // Register port
  input  wire [`AICR_ADDR_W-1:0]  reg_addr,
  input  wire [`AICR_DATA_W-1:0]  reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [`AICR_DATA_W-1:0]  reg_rdata,
  // Indicator and interrupt
  output reg                      active_led,
  output reg                      irq
);

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  localparam ACC_W = 16 + `AICR_FRAC_W;

  // Scale factor in counts per mV, Q16, from output format and range
  function [17:0] scale_factor;
    input       fa;
    input       fb;
    input       r10;
    begin
      case ({fa, fb})
        2'b11:   scale_factor = r10 ? `AICR_F4096_R10  : `AICR_F4096_R5;
        2'b10:   scale_factor = r10 ? `AICR_FFULL_R10  : `AICR_FFULL_R5;
        2'b01:   scale_factor = r10 ? `AICR_F10000_R10 : `AICR_F10000_R5;
        default: scale_factor = r10 ? `AICR_F4095_R10  : `AICR_F4095_R5;
      endcase
    end
  endfunction

  // Switch decode; a one means the switch is in its right position
  wire        mode_diff  = channel_mode_switch;
  wire [4:0]  chan_count = mode_diff ? 5'd8 : 5'd16;
  wire        range10    = ~range_select_switch;
  wire        unipolar   = polarity_select_switch;
  wire        offset_on  = offset_select_switch;
  wire        avg_bypass = averaging_select_switch_a & averaging_select_switch_b;
  wire [17:0] factor     = scale_factor(format_select_switch_a, format_select_switch_b, range10);
  wire [16:0] range_mv   = range10 ? `AICR_RANGE10_MV : `AICR_RANGE5_MV;
  reg  [2:0]  avg_shift;

  // Filter shift is log2 of twice the averaging depth
  always @* begin
    case ({averaging_select_switch_a, averaging_select_switch_b})
      2'b00:   avg_shift = `AICR_SHIFT_N8;
      2'b01:   avg_shift = `AICR_SHIFT_N16;
      2'b10:   avg_shift = `AICR_SHIFT_N32;
      default: avg_shift = `AICR_SHIFT_N8;
    endcase
  end

  // ----------------------------------------------------------------
  // Sample scaling
  // ----------------------------------------------------------------
  wire signed [17:0] mv_ext   = {{2{sample_mv[15]}}, sample_mv};
  wire signed [17:0] rng_s    = {1'b0, range_mv};
  // Unipolar offset removes a fifth of the range before scaling
  wire signed [17:0] off_s    = (unipolar && offset_on) ? (rng_s / 18'sd5) : 18'sd0;
  wire signed [17:0] top_s    = unipolar ? rng_s : (rng_s <<< 1);
  wire signed [17:0] shifted  = unipolar ? (mv_ext - off_s) : (mv_ext + rng_s);
  wire               s_oor    = (shifted < 18'sd0) || (shifted > top_s);
  wire [16:0]        s_mag    = s_oor ? 17'h0 : shifted[16:0];
  wire [34:0]        s_prod   = s_mag * factor;
  wire [15:0]        s_counts = unipolar ? s_prod[31:16] : s_prod[32:17];
  wire               s_take   = sample_valid && ({1'b0, sample_channel} < chan_count);

  // ----------------------------------------------------------------
  // Per-channel averaging store
  // ----------------------------------------------------------------
  reg [ACC_W-1:0]               acc_q [0:`AICR_MAX_CHANNELS-1];
  reg [`AICR_MAX_CHANNELS-1:0]  seen_q;
  reg [`AICR_MAX_CHANNELS-1:0]  oor_q;

  wire [ACC_W-1:0]   acc_cur  = acc_q[sample_channel];
  wire [ACC_W-1:0]   x_fix    = {s_counts, {`AICR_FRAC_W{1'b0}}};
  wire signed [ACC_W:0] diff  = $signed({1'b0, x_fix}) - $signed({1'b0, acc_cur});
  wire signed [ACC_W:0] step  = diff >>> avg_shift;
  wire [ACC_W:0]     acc_sum  = {1'b0, acc_cur} + step;
  // First sample of a channel loads directly so the filter does not ramp from zero
  wire [ACC_W-1:0]   acc_d    = (avg_bypass || !seen_q[sample_channel]) ? x_fix : acc_sum[ACC_W-1:0];

  // One accumulator per channel, written only by samples of that channel
  genvar gi;
  generate
    for (gi = 0; gi < `AICR_MAX_CHANNELS; gi = gi + 1) begin : g_chan
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          acc_q[gi] <= {ACC_W{1'b0}};
        end else if (clk_en && s_take && sample_channel == gi) begin
          acc_q[gi] <= acc_d;
        end
      end
    end
  endgenerate

  // Channels beyond the active count never hold back initialization
  wire [`AICR_MAX_CHANNELS-1:0] active_mask = mode_diff ? 16'h00ff : 16'hffff;
  wire [`AICR_MAX_CHANNELS-1:0] ch_bit      = 16'h0001 << sample_channel;
  wire                          init_done   = &(seen_q | ~active_mask);
  wire                          any_oor     = |(oor_q & active_mask);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_q <= 16'h0000;
    end else if (clk_en && s_take) begin
      seen_q <= seen_q | ch_bit;
    end
  end

  // Out-of-range flag follows the latest sample of each channel
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oor_q <= 16'h0000;
    end else if (clk_en && s_take) begin
      oor_q <= s_oor ? (oor_q | ch_bit) : (oor_q & ~ch_bit);
    end
  end

  // ----------------------------------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------------------------------
  reg  [`AICR_ST_W-1:0] status_q;
  reg  [`AICR_ST_W-1:0] mask_q;
  reg                   init_done_q;
  reg                   any_oor_q;
  wire [`AICR_ST_W-1:0] events;
  wire [`AICR_ST_W-1:0] w1c;

  // Events are the rising edges of init done and of any out of range
  assign events[`AICR_ST_INIT_DONE] = init_done & ~init_done_q;
  assign events[`AICR_ST_OOR]       = any_oor & ~any_oor_q;
  // Write-one-to-clear pattern of the status register
  assign w1c = (reg_wr && reg_addr == `AICR_STATUS_ADDR) ? reg_wdata[`AICR_ST_W-1:0] : {`AICR_ST_W{1'b0}};
  wire [`AICR_ST_W-1:0] status_d = (status_q & ~w1c) | events;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_done_q <= 1'b0;
      any_oor_q   <= 1'b0;
    end else if (clk_en) begin
      init_done_q <= init_done;
      any_oor_q   <= any_oor;
    end
  end

  // Sticky status bits; a new event wins over a clearing write
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= {`AICR_ST_W{1'b0}};
    end else if (clk_en) begin
      status_q <= status_d;
    end
  end

  // Mask register, same layout as the status register
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= `AICR_MASK_RESET;
    end else if (clk_en && reg_wr && reg_addr == `AICR_MASK_ADDR) begin
      mask_q <= reg_wdata[`AICR_ST_W-1:0];
    end
  end

  // Level interrupt, includes events of the same cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(status_d & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  wire [3:0]  rd_ch    = reg_addr[3:0];
  wire [15:0] rd_value = oor_q[rd_ch] ? `AICR_OVER_VALUE : acc_q[rd_ch][ACC_W-1:`AICR_FRAC_W];
  reg  [15:0] rd_d;
  wire        chan_hit = (reg_addr < {1'b0, chan_count});

  // Channel window first, then status, mask and configuration
  always @* begin
    rd_d = 16'h0000;
    if (chan_hit) begin
      rd_d = init_done ? rd_value : `AICR_INIT_VALUE;
    end else begin
      case (reg_addr)
        `AICR_STATUS_ADDR: rd_d = {14'h0000, status_q};
        `AICR_MASK_ADDR:   rd_d = {14'h0000, mask_q};
        // Configuration readback: switches, link and data state
        `AICR_CONFIG_ADDR: begin
          rd_d[0]  = polarity_select_switch;
          rd_d[1]  = offset_select_switch;
          rd_d[2]  = format_select_switch_a;
          rd_d[3]  = format_select_switch_b;
          rd_d[4]  = averaging_select_switch_a;
          rd_d[5]  = averaging_select_switch_b;
          rd_d[6]  = channel_mode_switch;
          rd_d[7]  = range_select_switch;
          rd_d[8]  = host_link_up;
          rd_d[9]  = init_done;
          rd_d[10] = any_oor;
        end
        default:           rd_d = 16'h0000;
      endcase
    end
  end

  // Read data stand for one cycle and are zero otherwise
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_d : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Activity indicator
  // ----------------------------------------------------------------
  localparam LED_OFF   = 4'b0001;
  localparam LED_FAST  = 4'b0010;
  localparam LED_STEADY = 4'b0100;
  localparam LED_SLOW  = 4'b1000;

  reg [3:0]  led_state_q;
  reg [3:0]  led_state_d;
  reg [27:0] blink_cnt_q;
  reg        blink_q;

  // Indicator state from link and data validity
  always @* begin
    if (!host_link_up) begin
      led_state_d = LED_OFF;
    end else if (!init_done) begin
      led_state_d = LED_FAST;
    end else if (any_oor) begin
      led_state_d = LED_SLOW;
    end else begin
      led_state_d = LED_STEADY;
    end
  end

  // Half period in cycles for the current blink rate
  wire [27:0] half_cyc = (led_state_q == LED_FAST) ? FAST_HALF_CYC[27:0] : SLOW_HALF_CYC[27:0];

  // Half-period counter restarts whenever the indicator state changes
  wire        led_change = (led_state_d != led_state_q);
  wire        half_end   = (blink_cnt_q >= half_cyc - 28'h0000001);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      led_state_q <= LED_OFF;
    end else if (clk_en) begin
      led_state_q <= led_state_d;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      blink_cnt_q <= 28'h0000000;
    end else if (clk_en) begin
      if (led_change || half_end) begin
        blink_cnt_q <= 28'h0000000;
      end else begin
        blink_cnt_q <= blink_cnt_q + 28'h0000001;
      end
    end
  end

  // Blink phase starts lit so a state change shows at once
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      blink_q <= 1'b0;
    end else if (clk_en) begin
      if (led_change) begin
        blink_q <= 1'b1;
      end else if (half_end) begin
        blink_q <= ~blink_q;
      end
    end
  end

  // Indicator pin comes straight from a flip-flop
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_led <= 1'b0;
    end else if (clk_en) begin
      case (led_state_q)
        LED_OFF:    active_led <= 1'b0;
        LED_FAST:   active_led <= blink_q;
        LED_STEADY: active_led <= 1'b1;
        LED_SLOW:   active_led <= blink_q;
        default:    active_led <= 1'b0;
      endcase
    end
  end

endmodule

// [verif/aicr_top_asserts.sv]
// Port assertions for the analog input report block
`timescale 1ns/100ps
`include "aicr_defines.vh"
module aicr_top_asserts #(
  parameter SLOW_HALF_CYC = 32
) (
  // Clock and reset
  input wire        clk,
  input wire        nrst,
  input wire        clk_en,
  // Switches and link
  input wire        polarity_select_switch,
  input wire        offset_select_switch,
  input wire        format_select_switch_a,
  input wire        format_select_switch_b,
  input wire        averaging_select_switch_a,
  input wire        averaging_select_switch_b,
  input wire        channel_mode_switch,
  input wire        range_select_switch,
  input wire        host_link_up,
  // Register port and outputs
  input wire [4:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        active_led,
  input wire        irq
);
  wire [8:0] cfg = {host_link_up, range_select_switch, channel_mode_switch, averaging_select_switch_b,
                    averaging_select_switch_a, format_select_switch_b, format_select_switch_a,
                    offset_select_switch, polarity_select_switch};
  // Cycles the indicator has stayed dark while the link is up
  reg [31:0] low_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) low_q <= 32'h0;
    else low_q <= (active_led || !host_link_up) ? 32'h0 : low_q + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0)
    else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr > `AICR_CONFIG_ADDR |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  chk_diff_upper: assert property (reg_rd && channel_mode_switch && reg_addr[4:3] == 2'h1
    |=> reg_rdata == 16'h0)
    else $error("channel beyond eight answered in differential mode");
  chk_config_bits: assert property (reg_rd && reg_addr == `AICR_CONFIG_ADDR ##1 $stable(cfg)
    |-> reg_rdata[8:0] == cfg)
    else $error("configuration readback wrong");
  chk_link_dark: assert property (!host_link_up [*3] |-> !active_led)
    else $error("indicator lit without link");
  chk_blink_bound: assert property (host_link_up |-> low_q <= SLOW_HALF_CYC + 4)
    else $error("indicator dark too long with link up");
  chk_irq_masked: assert property (reg_wr && reg_addr == `AICR_MASK_ADDR && reg_wdata[1:0] == 2'h0
    ##1 !reg_wr [*2] |-> !irq)
    else $error("interrupt high with all sources masked");
  chk_status_width: assert property (reg_rd && reg_addr == `AICR_STATUS_ADDR |=> reg_rdata[15:2] == 14'h0)
    else $error("status upper bits set");
endmodule
bind aicr_top aicr_top_asserts #(.SLOW_HALF_CYC(SLOW_HALF_CYC)) u_chk (.clk(clk), .nrst(nrst), .clk_en(clk_en),
  .polarity_select_switch(polarity_select_switch), .offset_select_switch(offset_select_switch),
  .format_select_switch_a(format_select_switch_a), .format_select_switch_b(format_select_switch_b),
  .averaging_select_switch_a(averaging_select_switch_a), .averaging_select_switch_b(averaging_select_switch_b),
  .channel_mode_switch(channel_mode_switch), .range_select_switch(range_select_switch),
  .host_link_up(host_link_up), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .active_led(active_led), .irq(irq));

// [verif/aicr_host.sv]
// Host controller model that reads and writes the block registers
`timescale 1ns/100ps
module aicr_host (
  // Clock
  input wire        clk,
  // Register port
  output reg [4:0]  reg_addr,
  output reg [15:0] reg_wdata,
  output reg        reg_wr,
  output reg        reg_rd
);
  initial begin
    reg_addr = 5'h0;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task rd(input [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
  task wr(input [4:0] a, input [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
endmodule

// [verif/aicr_top_tb.sv]
// Self-checking bench for the analog input report block
`timescale 1ns/100ps
`include "aicr_defines.vh"
module aicr_top_tb;
  reg               clk = 1'b0;
  reg               nrst = 1'b0;
  reg               sv = 1'b0;
  reg               link = 1'b0;
  reg        [7:0]  sw = 8'h7d;
  reg        [3:0]  sch = 4'h0;
  reg signed [15:0] smv = 16'sh0;
  reg        [31:0] lfsr = 32'h4be3a010;
  reg        [15:0] expq[$];
  reg               pend = 1'b0;
  wire       [4:0]  ra;
  wire       [15:0] wd;
  wire       [15:0] rdata;
  wire              wr;
  wire              rdst;
  wire              led;
  wire              irq;
  integer           errors = 0;
  integer           tests_run = 0;
  integer           i;
  integer           n;
  integer           v[8];
  aicr_host host (.clk(clk), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rdst));
  aicr_top #(.FAST_HALF_CYC(8), .SLOW_HALF_CYC(32)) uut (.clk(clk), .nrst(nrst), .clk_en(1'b1),
    .polarity_select_switch(sw[0]), .offset_select_switch(sw[1]), .format_select_switch_a(sw[2]),
    .format_select_switch_b(sw[3]), .averaging_select_switch_a(sw[4]), .averaging_select_switch_b(sw[5]),
    .channel_mode_switch(sw[6]), .range_select_switch(sw[7]), .sample_valid(sv), .sample_channel(sch),
    .sample_mv(smv), .host_link_up(link), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rdst),
    .reg_rdata(rdata), .active_led(led), .irq(irq));
  initial forever #2 clk = ~clk;
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task give_verdict;
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(input string nm, input [15:0] e, input [15:0] s);
    tests_run = tests_run + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (pend) cmp("rdata", expq.pop_front(), rdata);
  end
  always @(posedge clk) pend <= rdst;
  task rd(input [4:0] a, input [15:0] e);
    expq.push_back(e);
    host.rd(a);
  endtask
  task smp(input [3:0] c, input [15:0] mv);
    @(posedge clk);
    sv <= 1'b1;
    sch <= c;
    smv <= mv;
    @(posedge clk);
    sv <= 1'b0;
  endtask
  task tog(input integer cyc, output integer t);
    reg l;
    t = 0;
    l = led;
    repeat (cyc) begin
      @(posedge clk);
      if (led !== l) t = t + 1;
      l = led;
    end
  endtask
  initial begin
    #100000;
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("led", {15'h0, led}, 16'h0);
    link <= 1'b1;
    rd(5'h00, `AICR_INIT_VALUE);
    rd(`AICR_CONFIG_ADDR, 16'h017d);
    rd(`AICR_MASK_ADDR, 16'h0);
    rd(5'h08, 16'h0);
    rd(5'h13, 16'h0);
    tog(40, n);
    cmp("fast blink", {15'h0, n >= 4 && n <= 6}, 16'h1);
    host.wr(`AICR_MASK_ADDR, 16'h0001);
    for (i = 0; i < 7; i = i + 1) smp(i[3:0], 16'd100);
    rd(5'h00, `AICR_INIT_VALUE);
    for (i = 0; i < 8; i = i + 1) begin
      lfsr = lfsr_next(lfsr);
      v[i] = lfsr % 10001;
      smp(i[3:0], v[i][15:0]);
    end
    for (i = 0; i < 8; i = i + 1) rd(i[4:0], (v[i] * 26844) >> 16);
    cmp("irq", {15'h0, irq}, 16'h1);
    host.wr(`AICR_STATUS_ADDR, 16'h0001);
    repeat (2) @(posedge clk);
    cmp("irq", {15'h0, irq}, 16'h0);
    tog(40, n);
    cmp("steady", {15'h0, n == 0 && led === 1'b1}, 16'h1);
    smp(4'h3, 16'd11000);
    rd(5'h03, `AICR_OVER_VALUE);
    tog(100, n);
    cmp("slow blink", {15'h0, n >= 2 && n <= 4}, 16'h1);
    for (i = 0; i < 4; i = i + 1) begin
      sw[3:2] <= i[1:0];
      smp(4'h0, 16'd5000);
      rd(5'h00, i == 3 ? 16'd2048 : i == 2 ? 16'd5000 : i == 1 ? 16'd3750 : 16'd2047);
    end
    sw[7] <= 1'b1;
    smp(4'h0, 16'd2500);
    rd(5'h00, 16'd2047);
    smp(4'h0, 16'd6000);
    rd(5'h00, `AICR_OVER_VALUE);
    sw[7] <= 1'b0;
    sw[0] <= 1'b0;
    smp(4'h0, -16'sd5000);
    rd(5'h00, 16'd1024);
    sw[0] <= 1'b1;
    smp(4'h0, -16'sd1);
    rd(5'h00, `AICR_OVER_VALUE);
    sw[6] <= 1'b0;
    rd(5'h08, `AICR_INIT_VALUE);
    for (i = 8; i < 16; i = i + 1) smp(i[3:0], 16'd4500);
    rd(5'h0f, 16'd1843);
    sw[5:4] <= 2'b00;
    smp(4'hf, 16'd0);
    rd(5'h0f, 16'd1727);
    host.wr(`AICR_MASK_ADDR, 16'h0003);
    repeat (2) @(posedge clk);
    cmp("irq", {15'h0, irq}, 16'h1);
    host.wr(`AICR_MASK_ADDR, 16'h0000);
    repeat (3) @(posedge clk);
    cmp("irq", {15'h0, irq}, 16'h0);
    give_verdict;
  end
endmodule
